// [verilog/acft_status.sv]
// Heartbeat capture, outstanding-transaction count and fault seconds timer

module acft_status #(
    parameter int CYCLES_PER_SECOND = acft_pkg::CYCLES_PER_SECOND
) (
    input wire logic clk_sys,                    // System clock, 40 MHz
    input wire logic reset,                      // Synchronous reset, active high
    input wire logic heartbeatEnable,            // Automatic heartbeat capture on
    input wire acft_pkg::acft_chain_s chain,     // Transaction events
    input wire logic lockstepClearCommand,       // Clear pulse for lock-step state
    input wire logic faultDebounced,             // Pulse: fault passed debounce
    input wire acft_pkg::acft_mode_s mode,       // Mode entries and alert levels
    input wire logic regRead,                    // Host read strobe
    input wire logic [7:0] regAddr,              // Host read address
    output logic [7:0] regReadData,              // Read data, valid next cycle
    output logic regReadValid,                   // Pulse: regReadData valid
    output logic [7:0] returnedHeartbeatByte,    // Last returned heartbeat
    output logic [2:0] outstandingTxnCount,      // Transactions in flight
    output logic [15:0] faultSeconds,            // Seconds since fault
    output logic faultTimerRunning               // Timer counting
);
    logic [7:0] heartbeat_q;
    logic [7:0] heartbeat_d;
    logic [2:0] txnCount_q;
    logic [2:0] txnCount_d;
    logic [15:0] seconds_q;
    logic [15:0] seconds_d;
    acft_pkg::acft_timer_e timer_q;
    acft_pkg::acft_timer_e timer_d;
    logic [7:0] rdData_d;
    logic secondTick;
    logic modeEntry;
    logic alertActive;
    logic timerStart;
    logic [7:0] readData_d;
    logic readValid_d;
    logic timerRunning_d;

    assign modeEntry = mode.sleepEntry | mode.safeMonEntry;
    assign alertActive = mode.sleepAlertFlag | mode.safeMonitorAlertFlag;
    assign timerStart = faultDebounced & alertActive;

    // Second pulses, realigned when a fault starts the timer
    acft_second_tick #(
        .CYCLES(CYCLES_PER_SECOND)
    ) u_tick (
        .clk_sys(clk_sys),
        .reset(reset),
        .restart(timerStart | modeEntry),
        .enable(timer_q == acft_pkg::TIMER_RUN),
        .tick(secondTick)
    );

    // Heartbeat capture and in-flight count
    always_comb begin
        heartbeat_d = heartbeat_q;
        txnCount_d = txnCount_q;
        if (heartbeatEnable && chain.txnReturned) begin
            heartbeat_d = chain.returnedByte;
        end
        // Simultaneous send and return leaves the count unchanged
        if (chain.txnSent && !chain.txnReturned) begin
            if (txnCount_q != acft_pkg::TXN_COUNT_MAX) begin
                txnCount_d = txnCount_q + 3'h1;
            end
        end else if (chain.txnReturned && !chain.txnSent) begin
            if (txnCount_q != acft_pkg::TXN_COUNT_RESET) begin
                txnCount_d = txnCount_q - 3'h1;
            end
        end
        // Clear command overrides any event in the same cycle
        if (lockstepClearCommand) begin
            txnCount_d = acft_pkg::TXN_COUNT_RESET;
        end
    end

    // Fault timer state and seconds count
    always_comb begin
        timer_d = timer_q;
        seconds_d = seconds_q;
        unique case (timer_q)
            acft_pkg::TIMER_IDLE: begin
                if (timerStart) begin
                    timer_d = acft_pkg::TIMER_RUN;
                end
            end
            acft_pkg::TIMER_RUN: begin
                if (!alertActive) begin
                    timer_d = acft_pkg::TIMER_IDLE;
                end else if (secondTick && seconds_q != acft_pkg::SECONDS_MAX) begin
                    seconds_d = seconds_q + 16'h0001;
                end
            end
        endcase
        // Mode entry zeroes the count and stops the timer; a fault on that same cycle still starts it
        if (modeEntry) begin
            seconds_d = acft_pkg::SECONDS_RESET;
            timer_d = timerStart ? acft_pkg::TIMER_RUN : acft_pkg::TIMER_IDLE;
        end
        timerRunning_d = (timer_d == acft_pkg::TIMER_RUN);
    end

    // Read decode; unmapped addresses read as zero
    always_comb begin
        rdData_d = acft_pkg::READ_UNMAPPED;
        if (regAddr == acft_pkg::RETURNED_HEARTBEAT_OFS + acft_pkg::READ_OFFSET_STEP) begin
            rdData_d = heartbeat_q;
        end else if (regAddr == acft_pkg::FAULT_SECONDS_LOW_OFS
                     + acft_pkg::READ_OFFSET_STEP) begin
            rdData_d = seconds_q[7:0];
        end else if (regAddr == acft_pkg::FAULT_SECONDS_HIGH_OFS
                     + acft_pkg::READ_OFFSET_STEP) begin
            rdData_d = seconds_q[15:8];
        end
        // Data holds between reads, so a slow host may fetch it late
        readData_d = regRead ? rdData_d : regReadData;
        readValid_d = regRead;
    end

    // Chain state and its mirrored outputs
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            heartbeat_q <= acft_pkg::HEARTBEAT_RESET;
            txnCount_q <= acft_pkg::TXN_COUNT_RESET;
            returnedHeartbeatByte <= acft_pkg::HEARTBEAT_RESET;
            outstandingTxnCount <= acft_pkg::TXN_COUNT_RESET;
        end else begin
            heartbeat_q <= heartbeat_d;
            txnCount_q <= txnCount_d;
            returnedHeartbeatByte <= heartbeat_d;
            outstandingTxnCount <= txnCount_d;
        end
    end

    // Timer state and its mirrored outputs
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            seconds_q <= acft_pkg::SECONDS_RESET;
            timer_q <= acft_pkg::TIMER_IDLE;
            faultSeconds <= acft_pkg::SECONDS_RESET;
            faultTimerRunning <= 1'b0;
        end else begin
            seconds_q <= seconds_d;
            timer_q <= timer_d;
            faultSeconds <= seconds_d;
            faultTimerRunning <= timerRunning_d;
        end
    end

    // Read port registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            regReadData <= acft_pkg::READ_UNMAPPED;
            regReadValid <= 1'b0;
        end else begin
            regReadData <= readData_d;
            regReadValid <= readValid_d;
        end
    end
endmodule : acft_status

// [verilog/acft_pkg.sv]
// Constants and carrier types for the heartbeat and fault-timer status block
package acft_pkg;
    // Register offsets: write offset, host reads at offset plus one
    localparam logic [7:0] RETURNED_HEARTBEAT_OFS = 8'hE6;
    localparam logic [7:0] FAULT_SECONDS_LOW_OFS = 8'hEA;
    localparam logic [7:0] FAULT_SECONDS_HIGH_OFS = 8'hEC;
    localparam logic [7:0] READ_OFFSET_STEP = 8'h01;
    // Field widths and reset values
    localparam int HEARTBEAT_W = 8;
    localparam int TXN_COUNT_W = 3;
    localparam int SECONDS_W = 16;
    localparam logic [7:0] HEARTBEAT_RESET = 8'h00;
    localparam logic [2:0] TXN_COUNT_RESET = 3'h0;
    localparam logic [2:0] TXN_COUNT_MAX = 3'h7;
    localparam logic [15:0] SECONDS_RESET = 16'h0000;
    localparam logic [15:0] SECONDS_MAX = 16'hFFFF;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    // Timing: system clock and one second
    localparam longint CLK_HZ = 40000000;
    localparam longint SECOND_S = 1;
    localparam int CYCLES_PER_SECOND = int'(CLK_HZ * SECOND_S);

    // Daisy-chain transaction events from the lock-step machinery
    typedef struct packed {
        logic txnSent;                // Frame left the transmit buffer
        logic txnReturned;            // Frame arrived in the receive buffer
        logic [7:0] returnedByte;     // Heartbeat byte carried back
    } acft_chain_s;

    // Low-power mode events and alert levels
    typedef struct packed {
        logic sleepEntry;             // Pulse: sleep mode starts
        logic safeMonEntry;           // Pulse: safe-monitoring mode starts
        logic sleepAlertFlag;         // Level: sleep alert status bit
        logic safeMonitorAlertFlag;   // Level: safe-monitor alert status bit
    } acft_mode_s;

    // Fault timer states
    typedef enum logic [1:0] {
        TIMER_IDLE = 2'b01,
        TIMER_RUN = 2'b10
    } acft_timer_e;
endpackage : acft_pkg

// [verilog/acft_second_tick.sv]
// Divider that yields a one-cycle pulse each second while enabled
module acft_second_tick #(
    parameter int CYCLES = acft_pkg::CYCLES_PER_SECOND
) (
    input wire logic clk_sys,   // System clock
    input wire logic reset,     // Synchronous reset, active high
    input wire logic restart,   // Start a fresh second
    input wire logic enable,    // Count while high
    output logic tick           // One-cycle pulse per second
);
    logic [31:0] count_q;
    logic [31:0] count_d;
    logic tick_d;

    // Next count; restart realigns so the first tick lands a full second later
    always_comb begin
        count_d = count_q;
        tick_d = 1'b0;
        if (restart) begin
            count_d = 32'h0;
        end else if (enable) begin
            if (count_q == 32'(CYCLES - 1)) begin
                count_d = 32'h0;
                tick_d = 1'b1;
            end else begin
                count_d = count_q + 32'h1;
            end
        end
    end

    // Register stage
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            count_q <= 32'h0;
            tick <= 1'b0;
        end else begin
            count_q <= count_d;
            tick <= tick_d;
        end
    end
endmodule : acft_second_tick

// [test/acft_status_chk.sv]
// Port-level assertions for the heartbeat and fault timer block
module acft_status_chk #(
    parameter int CYCLES_PER_SECOND = 4
) (
    input wire logic clk_sys, // Clock
    input wire logic reset, // Reset
    input wire logic heartbeatEnable, // Capture on
    input wire acft_pkg::acft_chain_s chain, // Chain events
    input wire logic lockstepClearCommand, // Clear pulse
    input wire logic faultDebounced, // Debounce pulse
    input wire acft_pkg::acft_mode_s mode, // Mode events
    input wire logic regRead, // Read strobe
    input wire logic [7:0] regAddr, // Read address
    input wire logic [7:0] regReadData, // Read data
    input wire logic regReadValid, // Read valid
    input wire logic [7:0] returnedHeartbeatByte, // Heartbeat
    input wire logic [2:0] outstandingTxnCount, // In flight
    input wire logic [15:0] faultSeconds, // Seconds
    input wire logic faultTimerRunning // Counting
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    // Either alert level keeps the timer alive; either entry zeroes it
    wire logic alert = mode.sleepAlertFlag | mode.safeMonitorAlertFlag;
    wire logic entry = mode.sleepEntry | mode.safeMonEntry;
    a_beat_take: assert property (chain.txnReturned && heartbeatEnable
        |=> returnedHeartbeatByte == $past(chain.returnedByte)) else $error("beat not taken");
    a_read_beat: assert property (regRead && regAddr == 8'hE7
        |=> regReadValid && regReadData == $past(returnedHeartbeatByte)) else $error("bad read");
    a_count_up: assert property (chain.txnSent && !chain.txnReturned &&
        !lockstepClearCommand && outstandingTxnCount != 3'h7
        |=> outstandingTxnCount == $past(outstandingTxnCount) + 3'h1) else $error("no count up");
    a_count_down: assert property (chain.txnReturned && !chain.txnSent &&
        !lockstepClearCommand && outstandingTxnCount != 3'h0
        |=> outstandingTxnCount == $past(outstandingTxnCount) - 3'h1) else $error("no count down");
    a_count_clear: assert property (lockstepClearCommand
        |=> outstandingTxnCount == 3'h0) else $error("count not cleared");
    a_secs_first: assert property ($rose(faultTimerRunning) && faultSeconds == 16'h0000
        ##0 (alert && !entry) [*6] |-> faultSeconds == 16'h0001 && $past(faultSeconds) == 16'h0000)
        else $error("first second wrong");
    a_secs_idle: assert property (!faultTimerRunning && !entry
        |=> $stable(faultSeconds)) else $error("seconds moved while idle");
    a_timer_start: assert property (faultDebounced && alert
        |=> faultTimerRunning) else $error("timer did not start");
    a_timer_stop: assert property (!alert
        |=> !faultTimerRunning) else $error("timer did not stop");
    a_secs_zero: assert property (entry
        |=> faultSeconds == 16'h0000) else $error("seconds not zeroed");
    a_secs_sat: assert property (faultSeconds == 16'hFFFF && !entry
        |=> faultSeconds == 16'hFFFF) else $error("seconds wrapped");
endmodule : acft_status_chk

bind acft_status acft_status_chk #(
    .CYCLES_PER_SECOND(CYCLES_PER_SECOND)
) chk_i (
    .clk_sys(clk_sys),
    .reset(reset),
    .heartbeatEnable(heartbeatEnable),
    .chain(chain),
    .lockstepClearCommand(lockstepClearCommand),
    .faultDebounced(faultDebounced),
    .mode(mode),
    .regRead(regRead),
    .regAddr(regAddr),
    .regReadData(regReadData),
    .regReadValid(regReadValid),
    .returnedHeartbeatByte(returnedHeartbeatByte),
    .outstandingTxnCount(outstandingTxnCount),
    .faultSeconds(faultSeconds),
    .faultTimerRunning(faultTimerRunning)
);

// [test/acft_host_model.sv]
// Host model that reads the status registers
module acft_host_model (
    input wire logic clk_sys, // System clock
    output logic regRead, // Read strobe
    output logic [7:0] regAddr, // Read address
    input wire logic [7:0] regReadData, // Returned data
    input wire logic regReadValid // Data valid pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        regRead = 1'b0;
        regAddr = 8'h00;
    end
    // One-cycle strobe; a missing valid pulse returns unknown so checks fail
    task read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(negedge clk_sys);
        regRead = 1'b1;
        regAddr = addr;
        @(negedge clk_sys);
        regRead = 1'b0;
        regAddr = ~addr;
        data = regReadValid ? regReadData : 8'hXX;
    endtask : read_reg
endmodule : acft_host_model

// [test/acft_status_bench.sv]
// Self-checking bench for the heartbeat and fault timer block
module acft_status_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, reset, heartbeatEnable, lockstepClearCommand, faultDebounced;
    logic regRead, regReadValid, faultTimerRunning;
    logic [7:0] regAddr, regReadData, returnedHeartbeatByte, rd;
    logic [2:0] outstandingTxnCount;
    logic [15:0] faultSeconds;
    acft_pkg::acft_chain_s chain;
    acft_pkg::acft_mode_s mode;
    int num_errors = 0;
    int n_checks = 0;
    // Short second keeps the timer tests to a few cycles
    acft_status #(
        .CYCLES_PER_SECOND(4)
    ) uut (
        .clk_sys(clk_sys),
        .reset(reset),
        .heartbeatEnable(heartbeatEnable),
        .chain(chain),
        .lockstepClearCommand(lockstepClearCommand),
        .faultDebounced(faultDebounced),
        .mode(mode),
        .regRead(regRead),
        .regAddr(regAddr),
        .regReadData(regReadData),
        .regReadValid(regReadValid),
        .returnedHeartbeatByte(returnedHeartbeatByte),
        .outstandingTxnCount(outstandingTxnCount),
        .faultSeconds(faultSeconds),
        .faultTimerRunning(faultTimerRunning)
    );
    acft_host_model host (
        .clk_sys(clk_sys),
        .regRead(regRead),
        .regAddr(regAddr),
        .regReadData(regReadData),
        .regReadValid(regReadValid)
    );
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task rchk(input logic [7:0] addr, input logic [7:0] exp);
        host.read_reg(addr, rd);
        chk(rd, exp);
    endtask : rchk
    task finish_test;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    // Whole run needs about 70 cycles
    initial begin
        repeat (2000) @(posedge clk_sys);
        num_errors++;
        finish_test();
    end
    initial begin
        {reset, heartbeatEnable, lockstepClearCommand, faultDebounced} = 4'h8;
        chain = '0;
        mode = '0;
        cyc(16);
        reset = 1'b0;
        rchk(8'hE7, 8'h00);
        rchk(8'hEB, 8'h00);
        rchk(8'hED, 8'h00);
        rchk(8'hE6, 8'h00);
        $display("reset test done");
        heartbeatEnable = 1'b1;
        chain.txnSent = 1'b1;
        cyc(8);
        chk(outstandingTxnCount, 16'h0007);
        chain = {1'b0, 1'b1, 8'h5A};
        cyc(1);
        chk(outstandingTxnCount, 16'h0006);
        heartbeatEnable = 1'b0;
        chain.returnedByte = 8'hA5;
        cyc(1);
        chain.txnReturned = 1'b0;
        chk(outstandingTxnCount, 16'h0005);
        rchk(8'hE7, 8'h5A);
        {lockstepClearCommand, chain.txnSent} = 2'h3;
        cyc(1);
        {lockstepClearCommand, chain.txnSent} = 2'h0;
        chk(outstandingTxnCount, 16'h0000);
        $display("chain test done");
        {mode.sleepAlertFlag, faultDebounced} = 2'h3;
        cyc(1);
        faultDebounced = 1'b0;
        cyc(9);
        rchk(8'hEB, 8'h02);
        rchk(8'hED, 8'h00);
        mode.sleepAlertFlag = 1'b0;
        cyc(6);
        // Third second lands during the reads, then the count must hold
        chk(faultSeconds, 16'h0003);
        faultDebounced = 1'b1;
        cyc(1);
        faultDebounced = 1'b0;
        chk(faultTimerRunning, 16'h0000);
        mode.safeMonEntry = 1'b1;
        cyc(1);
        mode.safeMonEntry = 1'b0;
        chk(faultSeconds, 16'h0000);
        {mode.safeMonitorAlertFlag, faultDebounced} = 2'h3;
        cyc(1);
        faultDebounced = 1'b0;
        cyc(5);
        chk(faultSeconds, 16'h0001);
        // Sleep entry with a fresh fault: zeroed, still running, counts again
        {mode.sleepEntry, faultDebounced} = 2'h3;
        cyc(1);
        {mode.sleepEntry, faultDebounced} = 2'h0;
        chk(faultSeconds, 16'h0000);
        chk(faultTimerRunning, 16'h0001);
        cyc(5);
        chk(faultSeconds, 16'h0001);
        $display("timer test done");
        finish_test();
    end
endmodule : acft_status_bench
